// ### rtl/lcdw_top.sv
/*
  Segment display frame timing, pixel mapping and DC-free waveform
  generator with an AXI4-Lite register slave and a masked interrupt.
  Assumes: one 250 MHz clock, synchronous active-low reset, the two slow
  oscillators arrive as asynchronous pins, sleep_req comes from core
  logic on aclk, and an analog stage turns level codes into voltages.
*/
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module lcdw_top #(
  parameter int COMMONS = 4,
  parameter int SEGMENTS = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`LCDW_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`LCDW_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic secondary_crystal_clock,
  input wire logic low_freq_internal_clock,
  input wire logic sleep_req,
  output lcdw_pkg::lcdw_level_t common_drive [COMMONS],
  output lcdw_pkg::lcdw_level_t segment_drive [SEGMENTS],
  output logic display_active_flag,
  output logic irq
);
  import lcdw_pkg::*;

  // Registers
  logic enable_q;
  logic waveform_kind_select_q;
  logic sleep_stop_select_q;
  logic [1:0] clock_source_q;
  logic [1:0] common_count_select_q;
  logic [3:0] frame_prescale_select_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  lcdw_byte_t pixel_data_regs_q [`LCDW_PIX_REGS];

  // Bus slave state
  logic aw_held_q, w_held_q;
  logic [`LCDW_ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic wr_go;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // Timing state
  lcdw_state_e state_q;
  logic active_q;
  logic [7:0] sys_div_q;
  logic [2:0] sync_q [2];
  logic [1:0] slow_level_q;
  logic [1:0] slow_rise;
  logic src_tick;
  logic [3:0] presc_cnt_q;
  logic base_tick;
  logic [5:0] half_cnt_q;
  logic [5:0] half_last;
  logic half_q;
  logic [1:0] com_idx_q;
  logic frame_odd_q;
  logic halt;
  logic running;
  logic slice_end;
  logic frame_end;
  logic shut_ev;
  logic frame_ev;
  logic phase;

  // AXI write path: address and data are taken independently
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      waddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      waddr_q <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb0_q <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  assign wr_hit = (waddr_q[1:0] == 2'h0) &&
                  (waddr_q <= `LCDW_OFF_PIX_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LCDW_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `LCDW_RESP_OKAY : `LCDW_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; all fields sit in byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= 1'b0;
      waveform_kind_select_q <= 1'b0;
      sleep_stop_select_q <= 1'b0;
      clock_source_q <= `LCDW_CS_SYS256;
      common_count_select_q <= `LCDW_MUX_STATIC;
      frame_prescale_select_q <= 4'h0;
      irq_mask_q <= 2'h0;
    end else if (wr_go && wstrb0_q) begin
      if (waddr_q == `LCDW_OFF_CTRL) begin
        enable_q <= wdata_q[`LCDW_CTRL_EN];
        waveform_kind_select_q <= wdata_q[`LCDW_CTRL_WFT];
        sleep_stop_select_q <= wdata_q[`LCDW_CTRL_SLP];
        clock_source_q <= wdata_q[`LCDW_CTRL_CS_LSB +: 2];
        common_count_select_q <= wdata_q[`LCDW_CTRL_MUX_LSB +: 2];
      end
      if (waddr_q == `LCDW_OFF_PRESC) begin
        frame_prescale_select_q <= wdata_q[3:0];
      end
      if (waddr_q == `LCDW_OFF_IRQ_MASK) begin
        irq_mask_q <= wdata_q[1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `LCDW_PIX_REGS; gi++) begin : g_pix
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pixel_data_regs_q[gi] <= 8'h00;
        end else if (wr_go && wstrb0_q &&
                     waddr_q == `LCDW_OFF_PIX0 + 8'(4 * gi)) begin
          pixel_data_regs_q[gi] <= wdata_q[7:0];
        end
      end
    end
  endgenerate

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q &
                     ~((wr_go && wstrb0_q && waddr_q == `LCDW_OFF_IRQ_STAT) ?
                       wdata_q[1:0] : 2'h0)) |
                    {frame_ev, shut_ev};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // AXI read path
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `LCDW_OFF_CTRL: begin
        rd_word[`LCDW_CTRL_EN] = enable_q;
        rd_word[`LCDW_CTRL_WFT] = waveform_kind_select_q;
        rd_word[`LCDW_CTRL_SLP] = sleep_stop_select_q;
        rd_word[`LCDW_CTRL_CS_LSB +: 2] = clock_source_q;
        rd_word[`LCDW_CTRL_MUX_LSB +: 2] = common_count_select_q;
        rd_word[`LCDW_CTRL_ACTIVE] = active_q;
      end
      `LCDW_OFF_PRESC: rd_word[3:0] = frame_prescale_select_q;
      `LCDW_OFF_IRQ_STAT: rd_word[1:0] = irq_stat_q;
      `LCDW_OFF_IRQ_MASK: rd_word[1:0] = irq_mask_q;
      default: begin
        if (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr >= `LCDW_OFF_PIX0 &&
            s_axi_araddr <= `LCDW_OFF_PIX_LAST) begin
          rd_word[7:0] = pixel_data_regs_q[4'((s_axi_araddr - `LCDW_OFF_PIX0) >> 2)];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LCDW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? `LCDW_RESP_OKAY : `LCDW_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Timing sources
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div_q <= 8'h00;
    end else begin
      sys_div_q <= sys_div_q + 8'h01;
    end
  end

  // Slow oscillators: three stages, edge counted once stages 2 and 3 agree
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync_q[gi] <= 3'h0;
          slow_level_q[gi] <= 1'b0;
        end else begin
          sync_q[gi] <= {sync_q[gi][1:0],
                         (gi == 0) ? secondary_crystal_clock : low_freq_internal_clock};
          if (sync_q[gi][1] == sync_q[gi][2]) begin
            slow_level_q[gi] <= sync_q[gi][2];
          end
        end
      end
      assign slow_rise[gi] = (sync_q[gi][1] == sync_q[gi][2]) && sync_q[gi][2] &&
                             !slow_level_q[gi];
    end
  endgenerate

  always_comb begin
    case (clock_source_q)
      `LCDW_CS_SYS256: src_tick = (sys_div_q == `LCDW_SYS_DIV_LAST);
      `LCDW_CS_XTAL: src_tick = slow_rise[0];
      `LCDW_CS_LFINT: src_tick = slow_rise[1];
      default: src_tick = 1'b0;
    endcase
  end

  // Sleep stop; the system clock source always stops
  assign halt = sleep_req &&
                (sleep_stop_select_q || clock_source_q == `LCDW_CS_SYS256);
  assign running = active_q && !halt;

  // Prescale divides by field value plus one
  assign base_tick = running && src_tick &&
                     (presc_cnt_q == frame_prescale_select_q);

  // Half slice is 16 x A base ticks; A is 4, 2, 1, 1
  always_comb begin
    case (common_count_select_q)
      `LCDW_MUX_STATIC: half_last = `LCDW_HALF_LAST_STATIC;
      `LCDW_MUX_HALF: half_last = `LCDW_HALF_LAST_HALF;
      default: half_last = `LCDW_HALF_LAST_MUX;
    endcase
  end

  assign slice_end = base_tick && (half_cnt_q == half_last) && half_q;
  assign frame_end = slice_end && (com_idx_q == common_count_select_q);

  always_ff @(posedge aclk) begin
    if (!aresetn || !active_q) begin
      presc_cnt_q <= 4'h0;
      half_cnt_q <= 6'h00;
      half_q <= 1'b0;
      com_idx_q <= 2'h0;
      frame_odd_q <= 1'b0;
    end else if (running && src_tick) begin
      presc_cnt_q <= base_tick ? 4'h0 : presc_cnt_q + 4'h1;
      if (base_tick) begin
        half_cnt_q <= (half_cnt_q == half_last) ? 6'h00 : half_cnt_q + 6'h01;
        if (half_cnt_q == half_last) begin
          half_q <= !half_q;
        end
        if (frame_end) begin
          com_idx_q <= 2'h0;
          frame_odd_q <= !frame_odd_q;
        end else if (slice_end) begin
          com_idx_q <= com_idx_q + 2'h1;
        end
      end
    end
  end

  // Active flag: stops only at a frame end; this leaves Type-A DC-free, but Type-B may stop with frame_odd_q low and one frame uninverted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
    end else if (enable_q) begin
      active_q <= 1'b1;
    end else if (frame_end) begin
      active_q <= 1'b0;
    end
  end

  assign shut_ev = active_q && !enable_q && frame_end;
  assign frame_ev = frame_end && waveform_kind_select_q &&
                    (common_count_select_q != `LCDW_MUX_STATIC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= LCDW_IDLE;
    end else begin
      case (state_q)
        LCDW_IDLE: state_q <= enable_q ? LCDW_RUN : LCDW_IDLE;
        LCDW_RUN: begin
          if (halt) begin
            state_q <= LCDW_HALT;
          end else if (shut_ev) begin
            state_q <= LCDW_IDLE;
          end
        end
        LCDW_HALT: state_q <= halt ? LCDW_HALT : (active_q ? LCDW_RUN : LCDW_IDLE);
        default: state_q <= LCDW_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_active_flag <= 1'b0;
    end else begin
      display_active_flag <= active_q;
    end
  end

  // Type-A inverts each half slice, Type-B once per frame
  assign phase = waveform_kind_select_q ? frame_odd_q : half_q;

  // Pins drive the lowest level outside RUN
  generate
    for (gi = 0; gi < COMMONS; gi++) begin : g_com
      always_ff @(posedge aclk) begin
        if (!aresetn || state_q != LCDW_RUN || !running) begin
          common_drive[gi] <= LCDW_V0;
        end else if (2'(gi) > common_count_select_q) begin
          common_drive[gi] <= LCDW_V0;
        end else if (2'(gi) == com_idx_q) begin
          common_drive[gi] <= phase ? LCDW_V0 : LCDW_V3;
        end else begin
          common_drive[gi] <= phase ? LCDW_V2 : LCDW_V1;
        end
      end
    end
    for (gi = 0; gi < SEGMENTS; gi++) begin : g_seg
      logic dark;
      assign dark = pixel_data_regs_q[4'(3 * com_idx_q) + 4'(gi / 8)][gi % 8];
      always_ff @(posedge aclk) begin
        if (!aresetn || state_q != LCDW_RUN || !running) begin
          segment_drive[gi] <= LCDW_V0;
        end else if (dark) begin
          segment_drive[gi] <= phase ? LCDW_V3 : LCDW_V0;
        end else if (common_count_select_q == `LCDW_MUX_STATIC) begin
          segment_drive[gi] <= phase ? LCDW_V0 : LCDW_V3;
        end else begin
          segment_drive[gi] <= phase ? LCDW_V1 : LCDW_V2;
        end
      end
    end
  endgenerate

endmodule : lcdw_top

`default_nettype wire

// ### rtl/lcdw_params.svh
/*
  Offsets, field positions, reset values and timing counts of the
  segment display frame and waveform generator.
  Assumes inclusion by bare name from the package and the test bench.
*/
`ifndef LCDW_PARAMS_SVH
`define LCDW_PARAMS_SVH

`define LCDW_ADDR_W 8
`define LCDW_OFF_CTRL 8'h00
`define LCDW_OFF_PRESC 8'h04
`define LCDW_OFF_IRQ_STAT 8'h08
`define LCDW_OFF_IRQ_MASK 8'h0C
`define LCDW_OFF_PIX0 8'h10
`define LCDW_OFF_PIX_LAST 8'h3C
`define LCDW_PIX_REGS 12

`define LCDW_CTRL_EN 0
`define LCDW_CTRL_WFT 1
`define LCDW_CTRL_SLP 2
`define LCDW_CTRL_CS_LSB 4
`define LCDW_CTRL_MUX_LSB 6
`define LCDW_CTRL_ACTIVE 8

`define LCDW_IRQ_SHUT 0
`define LCDW_IRQ_FRAME 1

`define LCDW_CS_SYS256 2'h0
`define LCDW_CS_XTAL 2'h1
`define LCDW_CS_LFINT 2'h2
`define LCDW_MUX_STATIC 2'h0
`define LCDW_MUX_HALF 2'h1

`define LCDW_SYS_DIV_LAST 8'hFF
`define LCDW_HALF_LAST_STATIC 6'h3F
`define LCDW_HALF_LAST_HALF 6'h1F
`define LCDW_HALF_LAST_MUX 6'h0F

`define LCDW_RESP_OKAY 2'h0
`define LCDW_RESP_SLVERR 2'h2

`endif

// ### rtl/lcdw_pkg.sv
/*
  Types of the segment display frame and waveform generator.
  Assumes the constants header is on the include path.
*/
`include "lcdw_params.svh"

package lcdw_pkg;
  typedef logic [1:0] lcdw_level_t;
  typedef logic [7:0] lcdw_byte_t;
  typedef enum logic [1:0] {LCDW_IDLE, LCDW_RUN, LCDW_HALT} lcdw_state_e;
  localparam lcdw_level_t LCDW_V0 = 2'h0;
  localparam lcdw_level_t LCDW_V1 = 2'h1;
  localparam lcdw_level_t LCDW_V2 = 2'h2;
  localparam lcdw_level_t LCDW_V3 = 2'h3;
endpackage : lcdw_pkg

// ### testbench/lcdw_props.sv
/* Port checker of the segment display timing block.
   Assumes binding to lcdw_top with the package compiled first. */
`timescale 1ns/1ns
`default_nettype none
module lcdw_props #(
  parameter int COMMONS = 4,
  parameter int SEGMENTS = 24
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lcdw_pkg::lcdw_level_t common_drive [COMMONS],
  input wire lcdw_pkg::lcdw_level_t segment_drive [SEGMENTS],
  input wire logic display_active_flag,
  input wire logic irq
);
  import lcdw_pkg::*;
  logic quiet;
  logic bad_pair;
  // Codes two apart on common 0 and a segment are never a valid pixel level
  always_comb begin
    quiet = 1'b1;
    bad_pair = 1'b0;
    for (int i = 0; i < COMMONS; i++) quiet &= (common_drive[i] == LCDW_V0);
    for (int n = 0; n < SEGMENTS; n++) begin
      quiet &= (segment_drive[n] == LCDW_V0);
      bad_pair |= ((common_drive[0] ^ segment_drive[n]) == 2'h2);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property ($rose(aresetn) |-> quiet && !irq && !display_active_flag
    && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs busy after reset");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_pixel_levels: assert property (!bad_pair)
    else $error("pixel drive outside two levels");
endmodule : lcdw_props

bind lcdw_top lcdw_props #(.COMMONS(COMMONS), .SEGMENTS(SEGMENTS)) u_props (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .common_drive, .segment_drive, .display_active_flag, .irq);
`default_nettype wire

// ### testbench/lcdw_glass.sv
/* Passive glass model: per pixel, sums of common minus segment level and its square.
   Assumes evenly spaced level codes and one sample per clock. */
`timescale 1ns/1ns
`default_nettype none
module lcdw_glass #(
  parameter int COMMONS = 4,
  parameter int SEGMENTS = 24
) (
  input wire logic aclk,
  input wire logic clear,
  input wire lcdw_pkg::lcdw_level_t common_drive [COMMONS],
  input wire lcdw_pkg::lcdw_level_t segment_drive [SEGMENTS]
);
  import lcdw_pkg::*;
  int dc_sum [COMMONS][SEGMENTS];
  int rms_sum [COMMONS][SEGMENTS];
  function automatic int diff(input int k, input int n);
    return int'(common_drive[k]) - int'(segment_drive[n]);
  endfunction : diff
  always @(posedge aclk) begin
    for (int k = 0; k < COMMONS; k++) begin
      for (int n = 0; n < SEGMENTS; n++) begin
        dc_sum[k][n] <= clear ? 0 : dc_sum[k][n] + diff(k, n);
        rms_sum[k][n] <= clear ? 0 : rms_sum[k][n] + diff(k, n) * diff(k, n);
      end
    end
  end
endmodule : lcdw_glass
`default_nettype wire

// ### testbench/lcd_frame_waveform_timing_test.sv
/* Self-checking bench of the display timing block.
   Assumes lcdw_top, the glass model and the bound checker are compiled. */
`timescale 1ns/1ns
`default_nettype none
`include "lcdw_params.svh"
module lcd_frame_waveform_timing_test;
  import lcdw_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic xtal = 1'b0;
  logic lfint = 1'b0;
  logic sleep_req = 1'b0;
  logic clr = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b0;
  logic rready = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, act, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  lcdw_level_t com [4];
  lcdw_level_t seg [24];
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  lcdw_top u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .secondary_crystal_clock(xtal), .low_freq_internal_clock(lfint), .sleep_req,
    .common_drive(com), .segment_drive(seg), .display_active_flag(act), .irq);
  lcdw_glass u_glass (.aclk, .clear(clr), .common_drive(com), .segment_drive(seg));
  always #2 aclk = ~aclk;
  // Crystal ticks every 6 clocks so frame lengths stay short
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) xtal <= ~xtal;
    if (cyc % 5 == 4) lfint <= ~lfint;
    if (cyc == 80000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic near(input string nm, input int e, input int g);
    check_count++;
    if (g < e - 6 || g > e + 6) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : near
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic da, dw, ta, tw;
    da = 1'b0;
    dw = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ta = !da && awready;
      tw = !dw && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      da |= ta;
      dw |= tw;
    end
    do @(negedge aclk); while (!bvalid);
    // Late ready so the slave must hold its answer
    @(posedge aclk);
    bready <= 1'b1;
    @(negedge aclk);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b1;
    @(negedge aclk);
    v = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (s !== v && n < 4000);
  endtask : wait_for
  // Stamp of the next rise of common 0 to its top level
  task automatic com_up(output int t);
    logic p;
    p = 1'b1;
    forever begin
      @(negedge aclk);
      if (com[0] === LCDW_V3 && !p) break;
      p = (com[0] === LCDW_V3);
    end
    t = cyc;
  endtask : com_up
  function automatic logic [7:0] pix(input int i);
    return 8'(i * 37 + 1);
  endfunction : pix
  function automatic logic [31:0] cw(input int en, input int waveform_kind_select, input int slp, input int cs,
    input int mux);
    return 32'(en + waveform_kind_select * 2 + slp * 4 + cs * 16 + mux * 64);
  endfunction : cw
  task automatic t_regs();
    for (int a = 0; a < 16; a += 4) begin
      rd(8'(a), d, r);
      chk("reset value", 32'h0, d);
    end
    rd(8'h40, d, r);
    chk("unmapped resp", 32'(`LCDW_RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    wr(8'h02, 32'h1, r);
    chk("unaligned resp", 32'(`LCDW_RESP_SLVERR), 32'(r));
    wr(`LCDW_OFF_CTRL, 32'h100, r);
    rd(`LCDW_OFF_CTRL, d, r);
    chk("read-only active", 32'h0, d);
    for (int i = 0; i < 12; i++) wr(`LCDW_OFF_PIX0 + 8'(4 * i), 32'hFFFFFF00 | pix(i), r);
    for (int i = 0; i < 12; i++) begin
      rd(`LCDW_OFF_PIX0 + 8'(4 * i), d, r);
      chk("pixel reg", {24'h0, pix(i)}, d);
    end
    wr(`LCDW_OFF_PRESC, 32'h1, r);
    rd(`LCDW_OFF_PRESC, d, r);
    chk("prescale", 32'h1, d);
    @(posedge aclk);
    wstrb <= 4'hE;
    wr(`LCDW_OFF_PRESC, 32'h5, r);
    wstrb <= 4'hF;
    rd(`LCDW_OFF_PRESC, d, r);
    chk("lane 0 off", 32'h1, d);
  endtask : t_regs
  task automatic t_rate();
    int t0, t1;
    for (int m = 0; m < 4; m++) begin
      wr(`LCDW_OFF_CTRL, cw(1, 0, 0, 1, m), r);
      com_up(t0);
      com_up(t0);
      com_up(t1);
      near("frame cycles", (m == 0 ? 4 : m == 1 ? 2 : 1) * (m + 1) * 2 * 32 * 6, t1 - t0);
    end
    rd(`LCDW_OFF_CTRL, d, r);
    chk("active bit", 32'h1, 32'(d[8]));
    chk("active flag", 32'h1, 32'(act));
  endtask : t_rate
  task automatic t_dc(input int waveform_kind_select);
    int t0, t1, lo, hi;
    logic [7:0] v;
    lo = 1 << 30;
    hi = -1;
    wr(`LCDW_OFF_CTRL, cw(1, waveform_kind_select, 0, 1, 3), r);
    com_up(t0);
    com_up(t0);
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    repeat (2 - waveform_kind_select) com_up(t1);
    near("two frames", 2 * 4 * 2 * 32 * 6, t1 - t0);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    for (int k = 0; k < 4; k++) begin
      for (int n = 0; n < 24; n++) begin
        v = pix(3 * k + n / 8);
        chk("pixel dc", 32'h0, 32'(u_glass.dc_sum[k][n]));
        if (v[n % 8]) lo = (u_glass.rms_sum[k][n] < lo) ? u_glass.rms_sum[k][n] : lo;
        else hi = (u_glass.rms_sum[k][n] > hi) ? u_glass.rms_sum[k][n] : hi;
      end
    end
    chk("dark above clear", 32'h1, 32'(lo > hi));
  endtask : t_dc
  task automatic t_frame_irq();
    wr(`LCDW_OFF_IRQ_MASK, 32'h2, r);
    wr(`LCDW_OFF_CTRL, cw(1, 1, 0, 1, 3), r);
    wr(`LCDW_OFF_IRQ_STAT, 32'h3, r);
    wait_for(irq, 1'b1);
    chk("frame irq", 32'h1, 32'(irq));
    wr(`LCDW_OFF_IRQ_STAT, 32'h2, r);
    repeat (3) @(negedge aclk);
    chk("irq after clear", 32'h0, 32'(irq));
    for (int c = 0; c < 2; c++) begin
      wr(`LCDW_OFF_CTRL, c ? cw(1, 0, 0, 1, 3) : cw(1, 1, 0, 1, 0), r);
      wr(`LCDW_OFF_IRQ_STAT, 32'h3, r);
      repeat (3500) @(posedge aclk);
      rd(`LCDW_OFF_IRQ_STAT, d, r);
      chk("no frame status", 32'h0, d & 32'h2);
    end
  endtask : t_frame_irq
  task automatic t_shutdown();
    wr(`LCDW_OFF_IRQ_MASK, 32'h0, r);
    wr(`LCDW_OFF_IRQ_STAT, 32'h3, r);
    wr(`LCDW_OFF_CTRL, cw(0, 0, 0, 1, 3), r);
    wait_for(act, 1'b0);
    chk("active after disable", 32'h0, 32'(act));
    repeat (3) @(negedge aclk);
    chk("masked irq", 32'h0, 32'(irq));
    rd(`LCDW_OFF_IRQ_STAT, d, r);
    chk("shutdown status", 32'h1, d & 32'h1);
    wr(`LCDW_OFF_IRQ_MASK, 32'h1, r);
    repeat (3) @(negedge aclk);
    chk("shutdown irq", 32'h1, 32'(irq));
    wr(`LCDW_OFF_IRQ_STAT, 32'h1, r);
    repeat (3) @(negedge aclk);
    chk("irq after clear", 32'h0, 32'(irq));
  endtask : t_shutdown
  // Source and stop select per pass: system stops, internal runs, crystal with stop
  task automatic t_sleep();
    for (int i = 0; i < 3; i++) begin
      wr(`LCDW_OFF_CTRL, cw(1, 0, i / 2, i == 0 ? 0 : 3 - i, 0), r);
      repeat (300) @(posedge aclk);
      chk("drive awake", 32'h3, 32'(com[0] ^ seg[0]));
      sleep_req <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk("drive asleep", i == 1 ? 32'h3 : 32'h0, 32'(com[0] | seg[0]));
      @(posedge aclk);
      sleep_req <= 1'b0;
    end
  endtask : t_sleep
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rate();
    t_dc(0);
    t_dc(1);
    t_frame_irq();
    t_shutdown();
    t_sleep();
    final_report();
  end
endmodule : lcd_frame_waveform_timing_test
`default_nettype wire
